// >>> design/ecsd_map.svh
/*
 * Constants of the chip-select decoder: control field positions, reset values,
 * the on-chip peripheral I/O window and counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef ECSD_MAP_SVH
`define ECSD_MAP_SVH

// Control byte layout
`define ECSD_CTL_WAIT_MSB   7
`define ECSD_CTL_WAIT_LSB   5
`define ECSD_CTL_IO_BIT     4
`define ECSD_CTL_EN_BIT     3

// Reset values
`define ECSD_CTL0_RST       8'he8
`define ECSD_CTLX_RST       8'h00
`define ECSD_LOWER_RST      8'h00
`define ECSD_UPPER0_RST     8'hff
`define ECSD_UPPERX_RST     8'h00

// On-chip peripheral I/O range 0080h-00FFh: high byte 00h with bit 7 set
`define ECSD_PERIPH_HI      8'h00
`define ECSD_PERIPH_BIT     7

// Counts
`define ECSD_NUM_SEL        4
`define ECSD_WAIT_W         3

`endif

// >>> design/ecsd_pkg.sv
/*
 * Types of the chip-select decoder.
 * Assumes ecsd_map.svh is compiled alongside.
 */
package ecsd_pkg;

    // Access sequencer states, one-hot
    typedef enum logic [2:0] {
        ECSD_ST_IDLE = 3'h1,
        ECSD_ST_WAIT = 3'h2,
        ECSD_ST_HOLD = 3'h4
    } ecsd_state_t;

endpackage : ecsd_pkg

// >>> design/ecsd_sel_if.sv
/*
 * Carrier between the decoder top and one window matcher: the window setup
 * of one select and the raw hit that comes back.
 * Assumes the top owns the setup registers.
 */
`timescale 1ns/1ns

interface ecsd_sel_if;
    logic       enable;
    logic       io_space;
    logic [7:0] lower;
    logic [7:0] upper;
    logic       hit;

    modport cfg   (output enable, output io_space, output lower, output upper, input hit);
    modport match (input enable, input io_space, input lower, input upper, output hit);
endinterface : ecsd_sel_if

// >>> design/ecsd_select_match.sv
/*
 * One select's address window compare, memory or I/O mode.
 * Assumes address and access kind are stable while an access is presented.
 */
`timescale 1ns/1ns
`include "ecsd_map.svh"

module ecsd_select_match (
    // Window setup and hit
    ecsd_sel_if.match   sel,
    // CPU access
    input  wire logic [23:0] addr_i,
    input  wire logic        mem_access_i,
    input  wire logic        io_access_i
);

    logic mem_hit;
    logic io_hit;
    logic periph;

    // Memory windows are whole 64 KB pages, bounds inclusive
    assign mem_hit = mem_access_i && !sel.io_space
                     && (addr_i[23:16] >= sel.lower)
                     && (addr_i[23:16] <= sel.upper);

    // Internal registers own 0080h-00FFh, so no external select there
    assign periph  = (addr_i[15:8] == `ECSD_PERIPH_HI) && addr_i[`ECSD_PERIPH_BIT];

    // I/O windows are one 256-byte block picked by the lower bound
    assign io_hit  = io_access_i && sel.io_space
                     && (addr_i[15:8] == sel.lower) && !periph;

    // Nothing matches until enabled
    assign sel.hit = sel.enable && (mem_hit || io_hit);

endmodule : ecsd_select_match

// >>> design/ecsd_decoder.sv
/*
 * External chip-select decoder: four programmable memory or I/O windows,
 * fixed priority, registered active-low select and strobe outputs, and a
 * per-select wait-state stall toward the CPU.
 * Assumes the CPU holds address, kind and direction steady from the cycle
 * access_valid_i rises until it drops it after access_ready_o.
 */
`timescale 1ns/1ns
`include "ecsd_map.svh"

// Summary of operation
// - Four independent selects, memory or I/O each
// - Space bit zero memory, one I/O
// - Reset puts every select in memory space
// - Select never asserts unless enabled
// - Memory hit when lower <= ADDR[23:16] <= upper
// - Lowest-numbered matching select wins alone
// - Memory hit drives select, memory strobe, direction low
// - Memory windows in 64 KB pages
// - I/O select covers one 256-byte block
// - Per-select wait count up to seven
// - Select 0 bounds 00h..FFh, others 00h
// - I/O hit when ADDR[15:8] equals lower
// - No I/O select in peripheral range
// - Each wait state stalls one clock
module ecsd_decoder #(
    parameter int NUM_SEL = `ECSD_NUM_SEL,
    parameter int WAIT_W  = `ECSD_WAIT_W
) (
    // Clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               rst_n_i,
    // Setup writes, one strobe per select
    input  wire logic [NUM_SEL-1:0] cfg_we_i,
    input  wire logic [7:0]         select_control_register_i,
    input  wire logic [7:0]         window_lower_bound_i,
    input  wire logic [7:0]         window_upper_bound_i,
    // Setup readback of the chosen select
    input  wire logic [1:0]         cfg_rd_sel_i,
    output logic [7:0]              select_control_register_o,
    output logic [7:0]              window_lower_bound_o,
    output logic [7:0]              window_upper_bound_o,
    // CPU access
    input  wire logic               access_valid_i,
    input  wire logic [23:0]        cpu_addr_i,
    input  wire logic               mem_access_i,
    input  wire logic               io_access_i,
    input  wire logic               write_i,
    output logic                    cpu_stall_o,
    output logic                    access_ready_o,
    // External bus
    output logic [NUM_SEL-1:0]      select_n_o,
    output logic                    memory_request_strobe_n_o,
    output logic                    io_request_strobe_n_o,
    output logic                    rd_n_o,
    output logic                    wr_n_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter check

    // Priority, readback index and control byte assume this shape
    if (NUM_SEL != 4 || WAIT_W != 3) begin : g_bad_param
        $error("ecsd_decoder supports four selects with a 3-bit wait field only");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Setup registers

    logic [7:0] ctl_q   [NUM_SEL];
    logic [7:0] ctl_d   [NUM_SEL];
    logic [7:0] lower_q [NUM_SEL];
    logic [7:0] lower_d [NUM_SEL];
    logic [7:0] upper_q [NUM_SEL];
    logic [7:0] upper_d [NUM_SEL];

    // A write strobe loads all three bytes of its select at once
    always_comb
    begin
        for (int i = 0; i < NUM_SEL; i++)
        begin
            ctl_d[i]   = cfg_we_i[i] ? select_control_register_i : ctl_q[i];
            lower_d[i] = cfg_we_i[i] ? window_lower_bound_i      : lower_q[i];
            upper_d[i] = cfg_we_i[i] ? window_upper_bound_i      : upper_q[i];
        end
    end

    // Select 0 comes up enabled over all memory so boot code can be fetched
    always_ff @(posedge sys_clk_i)
    begin
        for (int i = 0; i < NUM_SEL; i++)
        begin
            if (!rst_n_i)
            begin
                ctl_q[i]   <= (i == 0) ? `ECSD_CTL0_RST : `ECSD_CTLX_RST;
                lower_q[i] <= `ECSD_LOWER_RST;
                upper_q[i] <= (i == 0) ? `ECSD_UPPER0_RST : `ECSD_UPPERX_RST;
            end
            else
            begin
                ctl_q[i]   <= ctl_d[i];
                lower_q[i] <= lower_d[i];
                upper_q[i] <= upper_d[i];
            end
        end
    end

    // Readback is combinational from the setup flops
    assign select_control_register_o = ctl_q[cfg_rd_sel_i];
    assign window_lower_bound_o      = lower_q[cfg_rd_sel_i];
    assign window_upper_bound_o      = upper_q[cfg_rd_sel_i];

    ////////////////////////////////////////////////////////////////////////////////
    // Window matchers

    logic [NUM_SEL-1:0] hit;

    for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
        ecsd_sel_if sel_if ();

        assign sel_if.enable   = ctl_q[g][`ECSD_CTL_EN_BIT];
        assign sel_if.io_space = ctl_q[g][`ECSD_CTL_IO_BIT];
        assign sel_if.lower    = lower_q[g];
        assign sel_if.upper    = upper_q[g];
        assign hit[g]          = sel_if.hit;

        ecsd_select_match u_match (
            .sel          (sel_if.match),
            .addr_i       (cpu_addr_i),
            .mem_access_i (mem_access_i),
            .io_access_i  (io_access_i)
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority pick

    logic [NUM_SEL-1:0] win;
    logic [WAIT_W-1:0]  win_wait;
    logic               win_io;
    logic               any_win;

    // Walk from the top down so the lowest-numbered hit is left standing
    always_comb
    begin
        win      = '0;
        win_wait = '0;
        win_io   = 1'b0;
        for (int i = NUM_SEL - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                win      = '0;
                win[i]   = 1'b1;
                win_wait = ctl_q[i][`ECSD_CTL_WAIT_MSB:`ECSD_CTL_WAIT_LSB];
                win_io   = ctl_q[i][`ECSD_CTL_IO_BIT];
            end
        end
        any_win = |win;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Access sequencer and wait counter

    ecsd_pkg::ecsd_state_t state_q;
    ecsd_pkg::ecsd_state_t state_d;
    logic [WAIT_W-1:0]     cnt_q;
    logic [WAIT_W-1:0]     cnt_d;

    // Wait count is sampled once, at the start, so a mid-access write cannot stretch it
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ecsd_pkg::ECSD_ST_IDLE:
            begin
                if (access_valid_i)
                begin
                    cnt_d   = any_win ? win_wait : '0;
                    state_d = (any_win && win_wait != '0) ? ecsd_pkg::ECSD_ST_WAIT
                                                          : ecsd_pkg::ECSD_ST_HOLD;
                end
            end
            ecsd_pkg::ECSD_ST_WAIT:
            begin
                cnt_d = cnt_q - 1'b1;
                if (!access_valid_i)
                    state_d = ecsd_pkg::ECSD_ST_IDLE;
                else if (cnt_q == 3'h1)
                    state_d = ecsd_pkg::ECSD_ST_HOLD;
            end
            ecsd_pkg::ECSD_ST_HOLD:
            begin
                if (!access_valid_i)
                    state_d = ecsd_pkg::ECSD_ST_IDLE;
            end
            default:
            begin
                state_d = ecsd_pkg::ECSD_ST_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ecsd_pkg::ECSD_ST_IDLE;
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign cpu_stall_o    = (state_q == ecsd_pkg::ECSD_ST_WAIT);
    assign access_ready_o = (state_q == ecsd_pkg::ECSD_ST_HOLD);

    ////////////////////////////////////////////////////////////////////////////////
    // Registered bus outputs

    logic [NUM_SEL-1:0] sel_n_q;
    logic [NUM_SEL-1:0] sel_n_d;
    logic               memory_request_strobe_n_q;
    logic               memory_request_strobe_n_d;
    logic               io_request_strobe_n_q;
    logic               io_request_strobe_n_d;
    logic               rd_n_q;
    logic               rd_n_d;
    logic               wr_n_q;
    logic               wr_n_d;

    // Registering costs one cycle of latency but keeps the pins glitch free
    always_comb
    begin
        sel_n_d  = '1;
        memory_request_strobe_n_d = 1'b1;
        io_request_strobe_n_d = 1'b1;
        rd_n_d   = 1'b1;
        wr_n_d   = 1'b1;
        if (access_valid_i && any_win)
        begin
            sel_n_d  = ~win;
            memory_request_strobe_n_d = win_io;
            io_request_strobe_n_d = ~win_io;
            rd_n_d   = write_i;
            wr_n_d   = ~write_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            sel_n_q  <= '1;
            memory_request_strobe_n_q <= 1'b1;
            io_request_strobe_n_q <= 1'b1;
            rd_n_q   <= 1'b1;
            wr_n_q   <= 1'b1;
        end
        else
        begin
            sel_n_q  <= sel_n_d;
            memory_request_strobe_n_q <= memory_request_strobe_n_d;
            io_request_strobe_n_q <= io_request_strobe_n_d;
            rd_n_q   <= rd_n_d;
            wr_n_q   <= wr_n_d;
        end
    end

    assign select_n_o                = sel_n_q;
    assign memory_request_strobe_n_o = memory_request_strobe_n_q;
    assign io_request_strobe_n_o     = io_request_strobe_n_q;
    assign rd_n_o                    = rd_n_q;
    assign wr_n_o                    = wr_n_q;

endmodule : ecsd_decoder

// >>> sim/ecsd_monitor.sv
/* Checker of the decoder's external bus, stall and ready outputs.
   Assumes it is bound into every ecsd_decoder instance. */
`timescale 1ns/1ns
module ecsd_monitor #(
    parameter int NUM_SEL = 4
) (
    // Clock and reset
    input wire logic               sys_clk_i,
    input wire logic               rst_n_i,
    // CPU side
    input wire logic               access_valid_i,
    input wire logic [23:0]        cpu_addr_i,
    input wire logic               mem_access_i,
    input wire logic               io_access_i,
    input wire logic               write_i,
    input wire logic               cpu_stall_o,
    input wire logic               access_ready_o,
    // External bus
    input wire logic [NUM_SEL-1:0] select_n_o,
    input wire logic               memory_request_strobe_n_o,
    input wire logic               io_request_strobe_n_o,
    input wire logic               rd_n_o,
    input wire logic               wr_n_o
);
    // Short aliases keep the properties readable
    wire logic mq = memory_request_strobe_n_o;
    wire logic iq = io_request_strobe_n_o;
    wire logic any_sel = ~&select_n_o;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // Seven stalled cycles is the longest a select may ask for
    sequence full_wait_s;
        cpu_stall_o [*7];
    endsequence
    one_winner_a: assert property ($onehot0(~select_n_o))
        else $error("more than one select low");
    strobe_pair_a: assert property (any_sel |-> (mq ^ iq) && (rd_n_o ^ wr_n_o))
        else $error("select without one kind and one direction strobe");
    no_orphan_a: assert property (!(mq && iq && rd_n_o && wr_n_o) |-> any_sel)
        else $error("strobe low with no select");
    dir_match_a: assert property (any_sel |-> wr_n_o == !$past(write_i))
        else $error("direction strobe does not follow the access");
    mem_kind_a: assert property (!mq |-> $past(mem_access_i))
        else $error("memory strobe without memory access");
    io_range_a: assert property (!iq |-> $past(io_access_i)
        && $past(cpu_addr_i[15:7]) != 9'h001)
        else $error("I/O select in peripheral range or outside I/O access");
    idle_high_a: assert property (!access_valid_i |=> !any_sel && mq && iq)
        else $error("select active without an access");
    wait_limit_a: assert property (full_wait_s |=> !cpu_stall_o)
        else $error("stall longer than seven cycles");
    // An aborted wait also ends the stall, so only a stall that ended under a held access counts
    ready_after_a: assert property ($fell(cpu_stall_o) && $past(access_valid_i) |-> access_ready_o)
        else $error("no ready after the wait states");
    reset_quiet_a: assert property (disable iff (1'b0)
        !rst_n_i |=> !any_sel && !cpu_stall_o && !access_ready_o)
        else $error("outputs active after reset");
endmodule : ecsd_monitor

bind ecsd_decoder ecsd_monitor #(.NUM_SEL(NUM_SEL)) u_mon (.sys_clk_i, .rst_n_i,
    .access_valid_i, .cpu_addr_i, .mem_access_i, .io_access_i, .write_i, .cpu_stall_o,
    .access_ready_o, .select_n_o, .memory_request_strobe_n_o, .io_request_strobe_n_o,
    .rd_n_o, .wr_n_o);

// >>> sim/ecsd_ext_dev.sv
/* Model of the external memories and peripherals: counts accesses by select edges.
   Assumes select lines are registered and held for a whole access. */
`timescale 1ns/1ns
module ecsd_ext_dev (
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    // Selects from the decoder
    input wire logic [3:0] select_n_i,
    // Accesses seen
    output logic [7:0]     acc_cnt_o
);
    logic [3:0] prev_q;
    // A select held over wait states is still one access, so only falls count
    always_ff @(posedge sys_clk_i)
    begin
        prev_q <= rst_n_i ? select_n_i : 4'hf;
        acc_cnt_o <= rst_n_i ? acc_cnt_o + 8'(|(prev_q & ~select_n_i)) : 8'h00;
    end
endmodule : ecsd_ext_dev

// >>> sim/tb.sv
/* Self-checking bench of the chip-select decoder with an external device model.
   Assumes the monitor is bound by its own file. */
`timescale 1ns/1ns
module tb;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, access_valid_i = 1'b0;
    logic mem_access_i = 1'b0, io_access_i = 1'b0, write_i = 1'b0;
    logic [3:0] cfg_we_i = 4'h0;
    logic [1:0] cfg_rd_sel_i = 2'h0;
    logic [7:0] select_control_register_i = 8'h00, window_lower_bound_i = 8'h00;
    logic [7:0] window_upper_bound_i = 8'h00, acc_cnt;
    logic [23:0] cpu_addr_i = 24'h000000;
    logic [7:0] select_control_register_o, window_lower_bound_o, window_upper_bound_o;
    logic [3:0] select_n_o;
    logic cpu_stall_o, access_ready_o, memory_request_strobe_n_o;
    logic io_request_strobe_n_o, rd_n_o, wr_n_o;
    int miscompares = 0, checks_done = 0, hits = 0;
    wire logic [7:0] bus_w = {io_request_strobe_n_o, memory_request_strobe_n_o,
                              rd_n_o, wr_n_o, select_n_o};
    always #5 sys_clk_i = ~sys_clk_i;
    ecsd_decoder DUT (.sys_clk_i, .rst_n_i, .cfg_we_i, .select_control_register_i,
        .window_lower_bound_i, .window_upper_bound_i, .cfg_rd_sel_i,
        .select_control_register_o, .window_lower_bound_o, .window_upper_bound_o,
        .access_valid_i, .cpu_addr_i, .mem_access_i, .io_access_i, .write_i, .cpu_stall_o,
        .access_ready_o, .select_n_o, .memory_request_strobe_n_o, .io_request_strobe_n_o,
        .rd_n_o, .wr_n_o);
    ecsd_ext_dev u_dev (.sys_clk_i, .rst_n_i, .select_n_i(select_n_o), .acc_cnt_o(acc_cnt));
    ////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] g, e);
        checks_done++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One setup write: all three bytes of select k load together
    task automatic cfgw(input int k, input logic [7:0] c, l, h);
        @(posedge sys_clk_i);
        cfg_we_i <= 4'h1 << k;
        cfg_rd_sel_i <= 2'(k);
        select_control_register_i <= c;
        window_lower_bound_i <= l;
        window_upper_bound_i <= h;
        @(posedge sys_clk_i);
        cfg_we_i <= 4'h0;
        #1 chk(select_control_register_o, c);
        chk(window_lower_bound_o, l);
        chk(window_upper_bound_o, h);
    endtask : cfgw
    // One access; k is the expected winner (-1 none), n its wait count
    task automatic access(input logic [23:0] a, input logic i, w, input int k, n);
        logic [7:0] e;
        int c;
        e = (k < 0) ? 8'hff : {~i, i, w, ~w, ~(4'h1 << k)};
        hits += (k >= 0);
        @(posedge sys_clk_i);
        cpu_addr_i <= a;
        io_access_i <= i;
        mem_access_i <= ~i;
        write_i <= w;
        access_valid_i <= 1'b1;
        @(posedge sys_clk_i);
        #1 chk(bus_w, e);
        c = 0;
        while (cpu_stall_o === 1'b1 && c < 9)
        begin
            @(posedge sys_clk_i);
            #1 c++;
        end
        if (c > 8)
        begin
            miscompares++;
            wrap_up();
        end
        chk(8'(c), 8'(n));
        chk(bus_w, e);
        chk({7'h0, access_ready_o}, 8'h01);
        @(posedge sys_clk_i);
        access_valid_i <= 1'b0;
        @(posedge sys_clk_i);
        #1 chk(bus_w, 8'hff);
    endtask : access
    ////////////////////////////////////////
    // Reset, then the readback of every select against its reset value
    task automatic t_reset;
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge sys_clk_i);
            cfg_rd_sel_i <= 2'(k);
            #1 chk(select_control_register_o, k ? 8'h00 : 8'he8);
            chk(window_lower_bound_o, 8'h00);
            chk(window_upper_bound_o, k ? 8'h00 : 8'hff);
        end
        chk(bus_w, 8'hff);
    endtask : t_reset
    // Overlapping memory windows with distinct wait counts, bounds at the edges
    task automatic t_priority;
        access(24'h123456, 1'b0, 1'b0, 0, 7);
        cfgw(0, 8'h08, 8'h00, 8'h7f);
        cfgw(1, 8'h28, 8'h00, 8'h9f);
        cfgw(2, 8'h48, 8'ha0, 8'hcf);
        cfgw(3, 8'he8, 8'hd0, 8'hd0);
        access(24'h7fffff, 1'b0, 1'b1, 0, 0);
        access(24'h800000, 1'b0, 1'b0, 1, 1);
        access(24'ha00000, 1'b0, 1'b1, 2, 2);
        access(24'hd0ffff, 1'b0, 1'b0, 3, 7);
        access(24'hd10000, 1'b0, 1'b0, -1, 0);
        cfgw(3, 8'h00, 8'hd0, 8'hff);
        access(24'he00000, 1'b0, 1'b0, -1, 0);
    endtask : t_priority
    // I/O windows: one 256-byte block, peripheral range, memory kind refused
    task automatic t_io;
        cfgw(2, 8'h38, 8'h12, 8'hff);
        cfgw(1, 8'h18, 8'h00, 8'h00);
        access(24'h001234, 1'b1, 1'b1, 2, 1);
        access(24'h5a12ff, 1'b1, 1'b0, 2, 1);
        access(24'h001300, 1'b1, 1'b0, -1, 0);
        access(24'h000080, 1'b1, 1'b0, -1, 0);
        access(24'h00007f, 1'b1, 1'b1, 1, 0);
        access(24'h801234, 1'b0, 1'b0, -1, 0);
        chk(acc_cnt, 8'(hits));
    endtask : t_io
    ////////////////////////////////////////
    initial
    begin
        t_reset();
        t_priority();
        t_io();
        t_reset();
        wrap_up();
    end
endmodule : tb
